//--- fqm_consts.vh
// Purpose: Shared constants for the multi-queue FIFO control front end.
// Assumes: Included by bare name from every design file.
// Notes: Offsets are AHB byte addresses of aligned 32-bit words.
`ifndef FQM_CONSTS_VH
`define FQM_CONSTS_VH

// ==========================================================
// Geometry
`define QUEUE_N 8
`define QIDX_W 3
`define PTR_W 4
`define DATA_W 36
`define MEM_ADDR_W 7
`define CFG_W 32
`define CFG_DEFAULT 32'h00040004

// ==========================================================
// Register map
`define REG_ADDR_W 8
`define REG_STATUS 8'h00
`define REG_CONFIG 8'h04
`define REG_CONTROL 8'h08
`define REG_MARKS 8'h0C
`define CTRL_CLEAR 0
`define CTRL_FREEZE 1

// ==========================================================
// AHB-Lite encodings
`define HTRANS_ACTIVE 1
`define HRESP_OKAY 1'h0

`endif

//--- cfg_shift.v
// Purpose: Serial loader for the configuration (offset) registers.
// Assumes: serial_clk and serial_in are synchronous to hclk.
// Notes: Bits shift in most significant first on each rising serial_clk.
`timescale 1ns/1ps
`include "fqm_consts.vh"

module cfg_shift (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   input wire clear,
   // Serial load pins
   input wire serial_load_enable,
   input wire serial_clk,
   input wire serial_in,
   // Configuration contents
   output reg [`CFG_W-1:0] cfg_r
);

   // ==========================================================
   // Edge detection of the sampled serial clock
   reg serial_clk_d_r;
   wire serial_rise;

   assign serial_rise = serial_clk & ~serial_clk_d_r;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_clk_d_r <= 1'b0;
         cfg_r <= `CFG_DEFAULT;
      end else begin
         serial_clk_d_r <= serial_clk;
         if (clear) begin
            cfg_r <= `CFG_DEFAULT;
         end else if (serial_rise && serial_load_enable) begin
            cfg_r <= {cfg_r[`CFG_W-2:0], serial_in};
         end
      end
   end

endmodule // cfg_shift

//--- fqm_ctrl.v
// Purpose: Control front end of a multi-queue FIFO with mark, rewind and mailbox.
// Assumes: All pins are synchronous to hclk; the memory array sits outside
//    and returns mem_rdata in the same cycle as mem_raddr.
// Notes: Registers are reached over AHB-Lite with zero wait states.
//
// What this block does
// - Mark pin stores the selected read queue's present read pointer.
// - A retransmit returns the read pointer to the latest mark.
// - Mailbox select steers writes and reads to the mailbox register.
// - Three-bit write queue index picks which of eight queues is written.
// - Three-bit read queue index picks which of eight queues is read.
// - Configuration changes only while serial load enable is active, or on a clear.
// - Serial input is taken as configuration only while loading is enabled.
// - Each serial clock rise with enable shifts one bit into the offsets.
// - Rewind reloads read pointer with mark; later reads replay up to write pointer.
// - Master clear zeroes pointers and output register, restores the default configuration and sets every empty flag.
`timescale 1ns/1ps
`include "fqm_consts.vh"

module fqm_ctrl (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Control pins
   input wire master_clear,
   input wire mailbox_select,
   input wire [`QIDX_W-1:0] write_queue_index,
   input wire [`QIDX_W-1:0] read_queue_index,
   input wire mark,
   input wire rewind_pulse,
   // Serial configuration pins
   input wire serial_load_enable,
   input wire serial_clk,
   input wire serial_in,
   // Host write port
   input wire wr_en,
   input wire [`DATA_W-1:0] wr_data,
   // Host read port
   input wire rd_en,
   output reg [`DATA_W-1:0] rd_data,
   output reg rd_valid,
   // Memory array port
   output wire mem_we,
   output wire [`MEM_ADDR_W-1:0] mem_waddr,
   output wire [`DATA_W-1:0] mem_wdata,
   output wire mem_re,
   output wire [`MEM_ADDR_W-1:0] mem_raddr,
   input wire [`DATA_W-1:0] mem_rdata,
   // Status
   output wire [`QUEUE_N-1:0] empty_flags,
   output wire [`QUEUE_N-1:0] full_flags,
   output wire [`CFG_W-1:0] cfg_out
);

   // ==========================================================
   // Pointer helpers
   // Pointers carry one wrap bit above the address so full and empty differ.
   function is_empty;
      input [`PTR_W:0] wp;
      input [`PTR_W:0] rp;
      begin
         is_empty = (wp == rp);
      end
   endfunction

   function is_full;
      input [`PTR_W:0] wp;
      input [`PTR_W:0] rp;
      begin
         is_full = (wp[`PTR_W] != rp[`PTR_W]) &&
            (wp[`PTR_W-1:0] == rp[`PTR_W-1:0]);
      end
   endfunction

   // ==========================================================
   // State
   reg [`PTR_W:0] wptr_r [0:`QUEUE_N-1];
   reg [`PTR_W:0] rptr_r [0:`QUEUE_N-1];
   reg [`PTR_W:0] mark_r [0:`QUEUE_N-1];
   reg [`DATA_W-1:0] mailbox_r;
   reg freeze_r;
   reg soft_clear_r;
   reg wr_pend_r;
   reg [`REG_ADDR_W-1:0] waddr_r;
   wire clear;
   wire wr_go;
   wire rd_go;
   wire wr_ok;
   wire rd_ok;
   wire [`PTR_W:0] wq_wptr;
   wire [`PTR_W:0] wq_rptr;
   wire [`PTR_W:0] rq_wptr;
   wire [`PTR_W:0] rq_rptr;
   wire [`CFG_W-1:0] cfg_r;
   integer q;

   assign clear = master_clear | soft_clear_r;

   // ==========================================================
   // Queue selection
   assign wq_wptr = wptr_r[write_queue_index];
   assign wq_rptr = rptr_r[write_queue_index];
   assign rq_wptr = wptr_r[read_queue_index];
   assign rq_rptr = rptr_r[read_queue_index];

   assign wr_go = wr_en & ~freeze_r & ~clear;
   assign rd_go = rd_en & ~freeze_r & ~clear & ~rewind_pulse;
   // Reads stall on an empty queue, which also ends a replay at the write pointer.
   assign wr_ok = wr_go & ~mailbox_select & ~is_full(wq_wptr, wq_rptr);
   assign rd_ok = rd_go & ~mailbox_select & ~is_empty(rq_wptr, rq_rptr);

   assign mem_we = wr_ok;
   assign mem_waddr = {write_queue_index, wq_wptr[`PTR_W-1:0]};
   assign mem_wdata = wr_data;
   assign mem_re = rd_ok;
   assign mem_raddr = {read_queue_index, rq_rptr[`PTR_W-1:0]};

   genvar g;
   generate
      for (g = 0; g < `QUEUE_N; g = g + 1) begin : g_flag
         assign empty_flags[g] = is_empty(wptr_r[g], rptr_r[g]);
         assign full_flags[g] = is_full(wptr_r[g], rptr_r[g]);
      end
   endgenerate

   // ==========================================================
   // Pointers, mark and rewind
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (q = 0; q < `QUEUE_N; q = q + 1) begin
            wptr_r[q] <= {(`PTR_W+1){1'b0}};
            rptr_r[q] <= {(`PTR_W+1){1'b0}};
            mark_r[q] <= {(`PTR_W+1){1'b0}};
         end
      end else if (clear) begin
         for (q = 0; q < `QUEUE_N; q = q + 1) begin
            wptr_r[q] <= {(`PTR_W+1){1'b0}};
            rptr_r[q] <= {(`PTR_W+1){1'b0}};
            mark_r[q] <= {(`PTR_W+1){1'b0}};
         end
      end else begin
         if (wr_ok) begin
            wptr_r[write_queue_index] <= wq_wptr + 1'b1;
         end
         // A mark taken with a read in the same cycle keeps the pre-read position.
         if (mark) begin
            mark_r[read_queue_index] <= rq_rptr;
         end
         if (rewind_pulse) begin
            rptr_r[read_queue_index] <= mark_r[read_queue_index];
         end else if (rd_ok) begin
            rptr_r[read_queue_index] <= rq_rptr + 1'b1;
         end
      end
   end

   // ==========================================================
   // Mailbox and output register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mailbox_r <= {`DATA_W{1'b0}};
         rd_data <= {`DATA_W{1'b0}};
         rd_valid <= 1'b0;
      end else if (clear) begin
         mailbox_r <= {`DATA_W{1'b0}};
         rd_data <= {`DATA_W{1'b0}};
         rd_valid <= 1'b0;
      end else begin
         if (wr_go && mailbox_select) begin
            mailbox_r <= wr_data;
         end
         rd_valid <= 1'b0;
         if (rd_go && mailbox_select) begin
            rd_data <= mailbox_r;
            rd_valid <= 1'b1;
         end else if (rd_ok) begin
            rd_data <= mem_rdata;
            rd_valid <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Serial configuration loader
   cfg_shift u_cfg (
      .hclk(hclk),
      .hresetn(hresetn),
      .clear(clear),
      .serial_load_enable(serial_load_enable),
      .serial_clk(serial_clk),
      .serial_in(serial_in),
      .cfg_r(cfg_r)
   );

   assign cfg_out = cfg_r;

   // ==========================================================
   // AHB-Lite register slave
   // Zero wait states; read data is captured at the address phase, so a
   // status read shows the state one edge before the data phase.
   wire addr_phase;
   reg [31:0] rd_mux;

   assign addr_phase = hsel & hready & htrans[`HTRANS_ACTIVE];
   assign hreadyout = 1'b1;
   assign hresp = `HRESP_OKAY;

   always @* begin
      rd_mux = 32'h00000000;
      case (haddr[`REG_ADDR_W-1:0])
         `REG_STATUS: rd_mux = {16'h0000, full_flags, empty_flags};
         `REG_CONFIG: rd_mux = cfg_r;
         `REG_CONTROL: rd_mux = {30'h00000000, freeze_r, 1'b0};
         `REG_MARKS: rd_mux = {22'h000000, mark_r[read_queue_index],
            rq_rptr};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         wr_pend_r <= 1'b0;
         waddr_r <= {`REG_ADDR_W{1'b0}};
         freeze_r <= 1'b0;
         soft_clear_r <= 1'b0;
      end else begin
         soft_clear_r <= 1'b0;
         if (wr_pend_r && waddr_r == `REG_CONTROL) begin
            freeze_r <= hwdata[`CTRL_FREEZE];
            soft_clear_r <= hwdata[`CTRL_CLEAR];
         end
         if (hready) begin
            wr_pend_r <= addr_phase & hwrite;
            waddr_r <= haddr[`REG_ADDR_W-1:0];
            if (addr_phase && !hwrite) begin
               hrdata <= rd_mux;
            end
         end
      end
   end

endmodule // fqm_ctrl

//--- fqm_ctrl_checker.sv
// Purpose: Port-level checks on the queue control front end.
// Assumes: One hclk domain.
// Notes: Bound to every fqm_ctrl instance.
`timescale 1ns/1ps
`include "fqm_consts.vh"
module fqm_ctrl_checker (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Control pins
   input wire master_clear,
   input wire mailbox_select,
   input wire [`QIDX_W-1:0] write_queue_index,
   input wire [`QIDX_W-1:0] read_queue_index,
   input wire rewind_pulse,
   input wire serial_load_enable,
   input wire serial_clk,
   input wire serial_in,
   input wire rd_en,
   // Outputs
   input wire [`DATA_W-1:0] rd_data,
   input wire rd_valid,
   input wire mem_we,
   input wire [`MEM_ADDR_W-1:0] mem_waddr,
   input wire mem_re,
   input wire [`MEM_ADDR_W-1:0] mem_raddr,
   input wire [`DATA_W-1:0] mem_rdata,
   input wire [`QUEUE_N-1:0] empty_flags,
   input wire [`CFG_W-1:0] cfg_out
);
   // ====
   // Properties
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_write_steer: assert property (mem_we |-> mem_waddr[6:4] == write_queue_index)
      else $error("write outside selected queue");
   a_read_steer: assert property (mem_re |-> mem_raddr[6:4] == read_queue_index)
      else $error("read outside selected queue");
   a_mbox_bypass: assert property (mailbox_select |-> !mem_we)
      else $error("mailbox write reached queue");
   a_read_data: assert property (rd_valid && !$past(mailbox_select)
      |-> rd_data == $past(mem_rdata)) else $error("read data mismatch");
   a_read_cause: assert property (rd_valid
      |-> $past(rd_en) && !$past(master_clear) && !$past(rewind_pulse))
      else $error("spurious read valid");
   a_rewind_wins: assert property (rewind_pulse && rd_en |=> !rd_valid)
      else $error("read taken during rewind");
   a_cfg_hold: assert property (!serial_load_enable && !$past(serial_load_enable)
      && !$past(master_clear) |-> $stable(cfg_out)) else $error("config moved");
   a_serial_shift: assert property ($past(serial_clk) && !$past(serial_clk, 2)
      && $past(serial_load_enable) && !$past(master_clear)
      |-> cfg_out == {$past(cfg_out[30:0]), $past(serial_in)}) else $error("bad shift");
   a_clear_all: assert property (master_clear |=> empty_flags == 8'hFF && rd_data == '0
      && !rd_valid && cfg_out == `CFG_DEFAULT) else $error("clear incomplete");
endmodule // fqm_ctrl_checker

bind fqm_ctrl fqm_ctrl_checker u_chk (.hclk, .hresetn, .master_clear, .mailbox_select,
   .write_queue_index, .read_queue_index, .rewind_pulse, .serial_load_enable,
   .serial_clk, .serial_in, .rd_en, .rd_data, .rd_valid, .mem_we, .mem_waddr,
   .mem_re, .mem_raddr, .mem_rdata, .empty_flags, .cfg_out);

//--- fifo_mem_model.sv
// Purpose: Memory array behind the queue control front end.
// Assumes: Read data is combinational from the read address.
// Notes: An idle read port shows inverted data, never the last value.
`timescale 1ns/1ps
`include "fqm_consts.vh"
module fifo_mem_model (
   // Clock
   input wire hclk,
   // Write side
   input wire mem_we,
   input wire [`MEM_ADDR_W-1:0] mem_waddr,
   input wire [`DATA_W-1:0] mem_wdata,
   // Read side
   input wire mem_re,
   input wire [`MEM_ADDR_W-1:0] mem_raddr,
   output wire [`DATA_W-1:0] mem_rdata
);
   // ====
   // Storage
   logic [`DATA_W-1:0] cells [0:127];
   always @(posedge hclk) begin
      if (mem_we) begin
         cells[mem_waddr] <= mem_wdata;
      end
   end
   assign mem_rdata = mem_re ? cells[mem_raddr] : ~cells[mem_raddr];
endmodule // fifo_mem_model

//--- fqm_ctrl_tb.sv
// Purpose: Self-checking bench for the queue control front end.
// Assumes: Zero-wait AHB slave, memory model on the array port.
// Notes: Nothing is printed but mismatches and the verdict.
`timescale 1ns/1ps
`include "fqm_consts.vh"
module fqm_ctrl_tb;
   // ====
   // Signals
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, r, cfg_out, sp = 32'h1234_5678;
   logic [1:0] htrans = '0;
   logic master_clear = 0, mailbox_select = 0, mark = 0, rewind_pulse = 0;
   logic [2:0] write_queue_index = '0, read_queue_index = '0;
   logic serial_load_enable = 0, serial_clk = 0, serial_in = 0;
   logic wr_en = 0, rd_en = 0, rd_valid, mem_we, mem_re;
   logic [35:0] wr_data = '0, rd_data, mem_wdata, mem_rdata;
   logic [6:0] mem_waddr, mem_raddr;
   logic [7:0] empty_flags, full_flags;
   int fails = 0, tests_run = 0;
   assign hready = hreadyout;
   always #2 hclk = ~hclk;
   fqm_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .master_clear, .mailbox_select,
      .write_queue_index, .read_queue_index, .mark, .rewind_pulse, .serial_load_enable,
      .serial_clk, .serial_in, .wr_en, .wr_data, .rd_en, .rd_data, .rd_valid, .mem_we,
      .mem_waddr, .mem_wdata, .mem_re, .mem_raddr, .mem_rdata, .empty_flags,
      .full_flags, .cfg_out);
   fifo_mem_model MEM (.hclk, .mem_we, .mem_waddr, .mem_wdata, .mem_re, .mem_raddr,
      .mem_rdata);
   // ====
   // Shared tasks
   task end_sim;
      if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input logic [35:0] g, input logic [35:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task push(input logic [2:0] q, input logic [35:0] d);
      @(posedge hclk);
      wr_en <= 1'b1;
      write_queue_index <= q;
      wr_data <= d;
      @(posedge hclk);
      wr_en <= 1'b0;
   endtask
   task pop(input logic [2:0] q, input logic v, input logic [35:0] e);
      @(posedge hclk);
      rd_en <= 1'b1;
      read_queue_index <= q;
      @(posedge hclk);
      rd_en <= 1'b0;
      #1;
      chk(rd_valid, v);
      if (v) chk(rd_data, e);
   endtask
   // A rewind also raises the read strobe, since rewind must win that cycle.
   task pins(input logic m, input logic rw);
      @(posedge hclk);
      mark <= m;
      rewind_pulse <= rw;
      rd_en <= rw;
      @(posedge hclk);
      mark <= 1'b0;
      rewind_pulse <= 1'b0;
      rd_en <= 1'b0;
   endtask
   task sbit(input logic b);
      @(posedge hclk);
      serial_in <= b;
      serial_clk <= 1'b0;
      @(posedge hclk);
      serial_clk <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask
   // ====
   // Scenarios
   task t_regs;
      #1;
      chk(empty_flags, 36'hFF);
      chk(cfg_out, `CFG_DEFAULT);
      ahb(1'b0, `REG_STATUS, 32'h0);
      chk(r, 36'hFF);
      ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h10, 32'h0);
      chk(r, 36'h0);
   endtask
   task t_steer;
      for (int q = 0; q < 8; q++) push(q[2:0], 36'hA0 + q);
      #1;
      chk(empty_flags, 36'h0);
      for (int q = 7; q >= 0; q--) pop(q[2:0], 1'b1, 36'hA0 + q);
   endtask
   task t_rewind;
      for (int i = 0; i < 4; i++) push(3'h5, 36'h50 + i);
      pop(3'h5, 1'b1, 36'h50);
      pins(1'b1, 1'b0);
      pop(3'h5, 1'b1, 36'h51);
      pop(3'h5, 1'b1, 36'h52);
      pins(1'b0, 1'b1);
      pop(3'h5, 1'b1, 36'h51);
      pins(1'b1, 1'b0);
      pop(3'h5, 1'b1, 36'h52);
      pins(1'b0, 1'b1);
      pop(3'h5, 1'b1, 36'h52);
      pop(3'h5, 1'b1, 36'h53);
      pop(3'h5, 1'b0, 36'h0);
      ahb(1'b0, `REG_MARKS, 32'h0);
      // Queue 5 pointers already stood at 1 from the steering test, so mark 3 and pointer 5.
      chk(r, 36'h65);
   endtask
   task t_mbox;
      @(posedge hclk);
      mailbox_select <= 1'b1;
      push(3'h6, 36'hF_00D0_0BEE);
      pop(3'h6, 1'b1, 36'hF_00D0_0BEE);
      chk(empty_flags, 36'hFF);
      @(posedge hclk);
      mailbox_select <= 1'b0;
   endtask
   task t_serial;
      for (int i = 0; i < 4; i++) sbit(1'b1);
      chk(cfg_out, `CFG_DEFAULT);
      @(posedge hclk);
      serial_load_enable <= 1'b1;
      for (int i = 31; i >= 0; i--) sbit(sp[i]);
      @(posedge hclk);
      serial_load_enable <= 1'b0;
      serial_clk <= 1'b0;
      #1;
      chk(cfg_out, sp);
      ahb(1'b0, `REG_CONFIG, 32'h0);
      chk(r, sp);
   endtask
   task t_clear;
      // One word more than the queue holds: the last one must be dropped.
      for (int i = 0; i <= (1 << `PTR_W); i++) push(3'h1, 36'h11 + i);
      #1;
      chk(full_flags, 36'h02);
      @(posedge hclk);
      master_clear <= 1'b1;
      @(posedge hclk);
      master_clear <= 1'b0;
      #1;
      chk(empty_flags, 36'hFF);
      chk(full_flags, 36'h0);
      chk(cfg_out, `CFG_DEFAULT);
      chk(rd_data, 36'h0);
      push(3'h4, 36'h44);
      ahb(1'b1, `REG_CONTROL, 32'h1);
      repeat (2) @(posedge hclk);
      ahb(1'b0, `REG_STATUS, 32'h0);
      chk(r, 36'hFF);
   endtask
   // ====
   // Sequence
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_steer;
      t_rewind;
      t_mbox;
      t_serial;
      t_clear;
      end_sim;
   end
   initial begin
      #40000;
      fails++;
      end_sim;
   end
endmodule // fqm_ctrl_tb
